// >>> dcpa_pkg.sv
// Package of constants, types and register map for the D-channel priority arbiter
package dcpa_pkg;

    // AXI4-Lite register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // Control register field positions
    localparam int CTRL_DMODE_LSB = 0;   // d_channel_mode_select, 3 bits
    localparam int CTRL_TMODE_LSB = 4;   // transceiver_mode_bits, 3 bits
    localparam int CTRL_D_PRIORITY_SELECT_BIT = 8;   // d_priority_select
    localparam int CTRL_TEFR_BIT  = 9;   // IOM-2 TE frame structure selected
    localparam int CTRL_TIC_BIT   = 10;  // address_arbitration_bus enabled
    localparam int CTRL_PCM12_BIT = 11;  // 12 PCM timeslots per frame
    localparam int CTRL_LTT_BIT   = 12;  // LT-T mode

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Mode encodings
    localparam logic [2:0] DMODE_COLL  = 3'h1;
    localparam logic [2:0] DMODE_MASK  = 3'h5;
    localparam logic [1:0] TMODE_INT_NT = 2'h3;

    // Stop/go position in the last channel-2 octet
    localparam int SG_BIT_POS = 5;

    // Ones thresholds
    localparam logic [3:0] THR_CLASS1 = 4'h8;
    localparam logic [3:0] THR_CLASS2 = 4'ha;
    localparam logic [3:0] CNT_MAX    = 4'hf;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Bit strobes extracted from the framing logic
    typedef struct packed {
        logic echo;     // received echo bit (S-bus E)
        logic dbit;     // upstream IOM-2 D bit
        logic bac;      // bus_accessed_flag from upstream_data_line
        logic ab;       // access-block bit from upstream device
    } dcpa_bits_t;

    typedef enum logic [2:0] {
        ST_MON  = 3'b001,
        ST_SEND = 3'b010,
        ST_LOC  = 3'b100
    } dcpa_state_t;

    // Priority class commands from the C/I channel
    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_AR8  = 2'h1,
        CMD_ACTIVATE_REQUEST_LOW_PRIO = 2'h2
    } dcpa_cmd_t;

endpackage

// >>> dcpa_arbiter.sv
// D-channel priority arbiter: S-bus access, stop/go and intelligent NT arbitration
`timescale 1ns/1ps

module dcpa_arbiter
    import dcpa_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Link side, bit clock sampled from the pin
    input  wire logic              link_clk,
    input  wire dcpa_pkg::dcpa_bits_t link_bits,
    input  wire logic              local_dbit,
    input  wire logic              tx_request,
    input  wire logic              frame_done,
    input  wire dcpa_pkg::dcpa_cmd_t ci_cmd,
    // Outputs
    output logic                   s_dbit,
    output logic                   s_echo,
    output logic                   stop_go_flag,
    output logic                   stop_go_output_pin,
    output logic                   tx_active,
    output logic                   collision
);
    import dcpa_pkg::*;

    logic [31:0]  ctrl;
    logic [2:0]   sync_clk;
    dcpa_bits_t   sync1;
    dcpa_bits_t   sync2;
    logic         bit_tick;
    logic [3:0]   ones_cnt;
    logic [3:0]   next_ones_cnt;
    logic [3:0]   threshold;
    logic         class2;
    logic         lower_level;
    logic         nt_lower;
    dcpa_state_t  state;
    logic         aw_hold;
    logic         w_hold;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         sg_stop;

    logic [2:0]   d_channel_mode_select;
    logic [2:0]   transceiver_mode_bits;
    logic         d_priority_select;
    logic         coll_on;
    logic         int_nt;
    logic         nt_ok;
    logic         ltt_pin_only;

    assign d_channel_mode_select = ctrl[CTRL_DMODE_LSB +: 3];
    assign transceiver_mode_bits = ctrl[CTRL_TMODE_LSB +: 3];
    assign d_priority_select     = ctrl[CTRL_D_PRIORITY_SELECT_BIT];
    assign coll_on = (d_channel_mode_select & DMODE_MASK) == DMODE_COLL;
    assign int_nt = transceiver_mode_bits[2:1] == TMODE_INT_NT;
    assign nt_ok = int_nt && ctrl[CTRL_TEFR_BIT] && ctrl[CTRL_PCM12_BIT] && ctrl[CTRL_TIC_BIT];
    assign ltt_pin_only = ctrl[CTRL_LTT_BIT] && !ctrl[CTRL_TEFR_BIT];

    // Threshold base plus one on the lower level
    function automatic logic [3:0] thr_of(input logic cls2, input logic low);
        logic [3:0] base;
        base = cls2 ? THR_CLASS2 : THR_CLASS1;
        thr_of = base + {3'h0, low};
    endfunction

    // NT uses priority select; TE uses class
    assign threshold = nt_ok ? thr_of(d_priority_select, nt_lower)
                             : thr_of(class2, lower_level);

    // Two-stage synchronisers; link clock edge is found past the second stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_clk <= 3'h0;
            sync1    <= '0;
            sync2    <= '0;
        end
        else if (clk_en)
        begin
            sync_clk <= {sync_clk[1:0], link_clk};
            sync1    <= link_bits;
            sync2    <= sync1;
        end
    end

    // Bits sampled on the rising link clock edge
    assign bit_tick = sync_clk[1] && !sync_clk[2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            class2 <= 1'b0;
        else if (clk_en)
        begin
            if (ci_cmd == CMD_AR8)
                class2 <= 1'b0;
            else if (ci_cmd == CMD_ACTIVATE_REQUEST_LOW_PRIO)
                class2 <= 1'b1;
        end
    end

    // in NT mode count IOM-2 D bits
    // counts above seven mean idle channel
    always_comb
    begin
        if ((nt_ok ? sync2.dbit : sync2.echo) == 1'b0)
            next_ones_cnt = 4'h0;
        else if (ones_cnt != CNT_MAX)
            next_ones_cnt = ones_cnt + 4'h1;
        else
            next_ones_cnt = ones_cnt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ones_cnt <= 4'h0;
        else if (clk_en && bit_tick)
            ones_cnt <= next_ones_cnt;
    end

    // Transmit state machine
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state <= ST_MON;
        else if (clk_en && bit_tick)
        begin
            unique case (state)
                ST_MON:
                begin
                    // grant at count with flag low
                    // Count includes the bit now taken, so access is not a bit late
                    if (nt_ok && sync2.ab && !sync2.bac && next_ones_cnt >= threshold)
                        state <= ST_LOC;
                    else if (!nt_ok && tx_request && next_ones_cnt >= threshold)
                        state <= ST_SEND;
                end
                ST_SEND:
                begin
                    if (coll_on && (sync2.echo != s_dbit))
                        state <= ST_MON;
                    else if (frame_done)
                        state <= ST_MON;
                end
                ST_LOC:
                begin
                    if (sync2.bac || !sync2.ab || !nt_ok)
                        state <= ST_MON;
                end
                default:
                    state <= ST_MON;
            endcase
        end
    end

    // lower level after success; cleared when raised count seen idle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            lower_level <= 1'b0;
        else if (clk_en && bit_tick)
        begin
            if (state == ST_SEND && frame_done && !(coll_on && sync2.echo != s_dbit))
                lower_level <= 1'b1;
            else if (state == ST_MON && !tx_request && lower_level
                     && next_ones_cnt >= threshold)
                lower_level <= 1'b0;
        end
    end

    // NT lower after success, base after abort
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            nt_lower <= 1'b0;
        else if (clk_en && bit_tick && state == ST_LOC)
        begin
            if (sync2.bac)
                nt_lower <= 1'b1;
            else if (!sync2.ab)
                nt_lower <= 1'b0;
        end
    end

    // Stop/go: stop unless transmit window open
    always_comb
    begin
        if (nt_ok)
            // access block forces stop; go at count; ready stops
            sg_stop = !(sync2.ab && state == ST_LOC);
        else
            sg_stop = !(ones_cnt >= threshold || state == ST_SEND);
    end

    // Link outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_dbit             <= 1'b1;
            s_echo             <= 1'b1;
            stop_go_flag       <= 1'b1;
            stop_go_output_pin <= 1'b1;
            tx_active          <= 1'b0;
            collision          <= 1'b0;
        end
        else if (clk_en)
        begin
            // ones while not sending; ones after collision
            s_dbit <= (state == ST_SEND) ? local_dbit : 1'b1;
            // inverted echo blocks terminals; plain
            // One echo bit per link bit, held until the next tick
            if (bit_tick)
                s_echo <= (state == ST_LOC) ? !sync2.dbit : sync2.dbit;
            // stop/go onto IOM; pin only in LT-T without TE frame structure
            stop_go_flag       <= ltt_pin_only ? 1'b1 : sg_stop;
            stop_go_output_pin <= sg_stop;
            tx_active          <= state == ST_SEND;
            collision          <= coll_on && state == ST_SEND && bit_tick
                                  && (sync2.echo != s_dbit);
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            ctrl         <= CTRL_RESET;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_hold && w_hold && !s_axi_bvalid)
            begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == ADDR_CTRL)
                begin
                    s_axi_bresp <= RESP_OKAY;
                    for (int i = 0; i < 4; i++)
                        if (w_strb[i])
                            ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
                end
                else if (aw_addr == ADDR_STATUS)
                    s_axi_bresp <= RESP_OKAY;
                else
                    s_axi_bresp <= RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Each ready only while its own channel and the response are idle, so one write at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_hold && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // AXI4-Lite read path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                if (s_axi_araddr == ADDR_CTRL)
                    s_axi_rdata <= ctrl;
                else if (s_axi_araddr == ADDR_STATUS)
                    s_axi_rdata <= {16'h0, 1'b0, state, threshold,
                                    ones_cnt, nt_lower, lower_level,
                                    class2, sg_stop};
                else
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // dcpa_arbiter

// >>> dcpa_arbiter_chk.sv
// Port assertions for the D-channel priority arbiter
`timescale 1ns/1ps

module dcpa_arbiter_chk
    import dcpa_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic tx_request,
    input wire logic s_dbit,
    input wire logic stop_go_flag,
    input wire logic stop_go_output_pin,
    input wire logic tx_active,
    input wire logic collision
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_pg; !stop_go_flag |-> !stop_go_output_pin; endproperty
    a_pg: assert property (p_pg) else $error("pin shows stop on go");
    property p_idle; !tx_active && !$past(tx_active) |-> s_dbit; endproperty
    a_idle: assert property (p_idle) else $error("zero sent while idle");
    property p_c1; collision |=> !collision; endproperty
    a_c1: assert property (p_c1) else $error("collision pulse too long");
    property p_cstop; collision |-> ##[0:2] (!tx_active && s_dbit); endproperty
    a_cstop: assert property (p_cstop) else $error("send not ceased");
    property p_ctx; collision |-> $past(tx_active); endproperty
    a_ctx: assert property (p_ctx) else $error("collision while silent");
    property p_treq; $rose(tx_active) |-> $past(tx_request); endproperty
    a_treq: assert property (p_treq) else $error("send without request");
    property p_tgo; tx_active && $past(tx_active) |-> !stop_go_output_pin; endproperty
    a_tgo: assert property (p_tgo) else $error("send under stop");
    property p_rnext; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rnext: assert property (p_rnext) else $error("late read answer");
endmodule // dcpa_arbiter_chk

bind dcpa_arbiter dcpa_arbiter_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .tx_request(tx_request),
    .s_dbit(s_dbit), .stop_go_flag(stop_go_flag), .stop_go_output_pin(stop_go_output_pin),
    .tx_active(tx_active), .collision(collision)
);

// >>> dcpa_l2_peer.sv
// Layer-2 side model: link bit clock and bit strobes toward the arbiter
`timescale 1ns/1ps

module dcpa_l2_peer
    import dcpa_pkg::*;
(
    output logic                 link_clk,
    output dcpa_pkg::dcpa_bits_t link_bits
);
    // Clock rests low between bits; pulled-up lines rest at one
    initial
    begin
        link_clk = 1'b0;
        link_bits = 4'hf;
    end

    // Bits settle away from aclk edges and hold around the rise
    task automatic send_bit(input dcpa_bits_t b);
        #13 link_bits = b;
        #200 link_clk = 1'b1;
        #186 link_clk = 1'b0;
        // released lines float back to ones
        link_bits = 4'hf;
        #1;
    endtask
endmodule // dcpa_l2_peer

// >>> tb_top.sv
// Self-checking bench for the D-channel priority arbiter
`timescale 1ns/1ps

module tb_top;
    import dcpa_pkg::*;

    localparam int LIMIT = 30000;
    localparam logic [31:0] CFG_TE = {29'h0, DMODE_COLL};
    localparam logic [31:0] CFG_NT = CFG_TE | (32'h6 << CTRL_TMODE_LSB) | (32'h7 << CTRL_TEFR_BIT);
    logic        aclk, aresetn, clk_en, local_dbit, tx_request, frame_done, coll_seen;
    logic        awvalid, wvalid, bready, arvalid, rready, link_clk;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        s_dbit, s_echo, stop_go_flag, stop_go_output_pin, tx_active, collision;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, st;
    logic [3:0]  wstrb, thr;
    logic [1:0]  bresp, rresp, rsp;
    dcpa_bits_t  link_bits;
    dcpa_cmd_t   ci_cmd;
    int          errors = 0, cmp_count = 0, cycles = 0;

    dcpa_arbiter dut (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_clk(link_clk),
        .link_bits(link_bits), .local_dbit(local_dbit), .tx_request(tx_request),
        .frame_done(frame_done), .ci_cmd(ci_cmd), .s_dbit(s_dbit), .s_echo(s_echo),
        .stop_go_flag(stop_go_flag), .stop_go_output_pin(stop_go_output_pin),
        .tx_active(tx_active), .collision(collision)
    );
    dcpa_l2_peer u_peer (.link_clk(link_clk), .link_bits(link_bits));

    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    always @(posedge aclk)
    begin
        cycles++;
        if (collision === 1'b1) coll_seen <= 1'b1;
        if (cycles == LIMIT)
        begin
            errors++;
            print_verdict();
        end
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rsp = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        st = rdata;
        rsp = rresp;
    endtask

    // Outputs settle a few cycles after each bit's rise
    task automatic nbits(input int n, input logic [3:0] b);
        repeat (n) u_peer.send_bit(b);
        repeat (4) @(posedge aclk);
    endtask

    task automatic print_verdict();
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {local_dbit, tx_request, frame_done, coll_seen} = '0;
        {awaddr, araddr, wdata} = '0;
        {clk_en, wstrb} = 5'h1f;
        ci_cmd = CMD_NONE;
        repeat (16) @(posedge aclk);
        chk({s_dbit, s_echo, stop_go_flag, tx_active}, 4'he);
        aresetn <= 1'b1;
        wr(ADDR_CTRL, CFG_TE);
        rd(ADDR_CTRL);
        chk({st, rsp}, {CFG_TE, RESP_OKAY});
        wr(8'h08, 32'h0);
        chk(rsp, RESP_SLVERR);
        rd(8'h08);
        chk({st, rsp}, {32'h0, RESP_SLVERR});
        for (int k = 0; k < 2; k++)
        begin
            thr = k ? THR_CLASS2 : THR_CLASS1;
            ci_cmd <= k ? CMD_ACTIVATE_REQUEST_LOW_PRIO : CMD_AR8;
            nbits(1, 4'h7);
            nbits(int'(thr) - 1, 4'hf);
            chk(stop_go_flag, 1'b1);
            nbits(1, 4'hf);
            chk({stop_go_flag, stop_go_output_pin}, 2'b00);
            rd(ADDR_STATUS);
            chk(st[11:8], thr);
            nbits(1, 4'h7);
            chk(stop_go_flag, 1'b1);
        end
        ci_cmd <= CMD_AR8;
        {tx_request, local_dbit} <= 2'h3;
        nbits(7, 4'hf);
        chk(tx_active, 1'b0);
        nbits(1, 4'hf);
        chk(tx_active, 1'b1);
        {local_dbit, coll_seen} <= 2'h0;
        nbits(3, 4'hf);
        chk({coll_seen, tx_active, s_dbit}, 3'b101);
        local_dbit <= 1'b1;
        nbits(1, 4'h7);
        nbits(8, 4'hf);
        frame_done <= 1'b1;
        nbits(1, 4'hf);
        {frame_done, tx_request} <= 2'h0;
        nbits(1, 4'h7);
        rd(ADDR_STATUS);
        chk({st[11:8], st[2], tx_active}, {THR_CLASS1 + 4'h1, 2'b10});
        nbits(8, 4'hf);
        chk(stop_go_flag, 1'b1);
        nbits(1, 4'hf);
        chk(stop_go_flag, 1'b0);
        rd(ADDR_STATUS);
        chk(st[2], 1'b0);
        wr(ADDR_CTRL, CFG_TE | (32'h1 << CTRL_LTT_BIT));
        nbits(1, 4'hf);
        chk({stop_go_flag, stop_go_output_pin}, 2'b10);
        for (int k = 0; k < 2; k++)
        begin
            thr = k ? THR_CLASS2 : THR_CLASS1;
            wr(ADDR_CTRL, CFG_NT | (32'(k) << CTRL_D_PRIORITY_SELECT_BIT));
            nbits(1, 4'hb);
            nbits(int'(thr) - 1, 4'hf);
            chk(stop_go_flag, 1'b1);
            // bus seen free, controller claims it
            nbits(1, 4'hd);
            chk(stop_go_flag, 1'b0);
            nbits(1, 4'h9);
            chk(s_echo, 1'b1);
            nbits(2, 4'hb);
            chk({s_echo, stop_go_flag}, 2'b01);
            nbits(int'(thr) - 1, 4'hf);
            nbits(1, 4'hd);
            chk(stop_go_flag, 1'b1);
            nbits(1, 4'hd);
            chk(stop_go_flag, 1'b0);
            nbits(1, 4'hc);
            chk(stop_go_flag, 1'b1);
            rd(ADDR_STATUS);
            chk(st[11:8], thr);
        end
        print_verdict();
    end
endmodule // tb_top
